// [bsil_chk_assertions.sv]
`timescale 1ns/1ns
module bsil_chk (
	input wire clk_in,
	input wire rst_in,
	input wire rst_pin_n_in,
	input wire boot_strap_bit2_in,
	input wire secure_boot_in,
	input wire pll_cfg_we_in,
	input wire [11:0] pll_mult_in,
	input wire gpio_pd_out,
	input wire in_reset_out,
	input wire [2:0] tile0_src_out,
	input wire [2:0] tile1_src_out,
	input wire [7:0] link_en_out,
	input wire [11:0] pll_mult_out,
	input wire [12:0] core_mult_out,
	input wire ram_we_out,
	input wire [31:0] ram_addr_out,
	input wire start_out,
	input wire [31:0] exec_addr_out,
	input wire crc_skipped_out,
	input wire fail_out
);
	wire any_rst = rst_in | ~rst_pin_n_in;
	reg [11:0] seq_ff;
	reg [29:0] wr_ff;
	// Cycles spent in the internal reset sequence, and RAM writes so far
	always @(posedge clk_in) begin
		seq_ff <= gpio_pd_out ? 12'h000 : (in_reset_out && seq_ff != 12'hFFF ? seq_ff + 12'h001 : seq_ff);
		wr_ff <= in_reset_out ? 30'h0 : wr_ff + {29'h0, ram_we_out};
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (any_rst);
	a_reset_pulldown: assert property (disable iff (1'b0) any_rst |=> gpio_pd_out && in_reset_out)
		else $error("pull-downs or reset flag missing in reset");
	a_seq_length: assert property ($fell(in_reset_out) |-> seq_ff >= 12'd295 && seq_ff <= 12'd3000)
		else $error("internal reset sequence length wrong");
	a_exec_zero: assert property (start_out |-> exec_addr_out == 32'h00000000)
		else $error("execution not at lowest address");
	a_ram_step: assert property (ram_we_out |-> ram_addr_out == {wr_ff, 2'b00})
		else $error("RAM write address out of sequence");
	a_fail_nostart: assert property (fail_out |-> !start_out && !crc_skipped_out)
		else $error("program started after CRC failure");
	a_magic_start: assert property ($rose(crc_skipped_out) && tile0_src_out != 3'h3 |-> ##[0:2] start_out)
		else $error("magic check word did not start program");
	a_strap_hold: assert property (!in_reset_out && $past(!in_reset_out) |->
		$stable(tile0_src_out) && $stable(tile1_src_out) && $stable(link_en_out))
		else $error("captured straps changed");
	a_no_links: assert property ($fell(in_reset_out) && !boot_strap_bit2_in |-> link_en_out == 8'h00)
		else $error("links enabled with strap bit2 low");
	a_link_boot: assert property ($fell(in_reset_out) && boot_strap_bit2_in |->
		tile1_src_out == 3'h3 && link_en_out != 8'h00)
		else $error("link boot setup wrong");
	a_otp_boot: assert property ($fell(in_reset_out) && secure_boot_in |-> tile0_src_out == 3'h4)
		else $error("secure boot did not select OTP");
	a_pll_write: assert property (!in_reset_out && pll_cfg_we_in |=> pll_mult_out == $past(pll_mult_in)
		##1 core_mult_out == {1'b0, $past(pll_mult_in, 2)} + 13'h0001)
		else $error("PLL write not applied");
	c_start: cover property ($rose(start_out));
	c_fail: cover property ($rose(fail_out));
	c_skip: cover property ($rose(crc_skipped_out));
endmodule // bsil_chk
bind bsil_top bsil_chk u_chk (.*);

// [bsil_consts.vh]
// Summary of operation
// - Pin reset low: hold reset, pull-downs on
// - Internal reset sequence before boot starts
// - Image: length, length words, check word
// - Magic check word skips CRC check
// - Length and check words LSB first
// - Load from lowest RAM, start there
// - CRC over length word and program
// - Reflected CRC-32, preset ones, inverted result
// - Secure boot bit forces OTP boot
// - Strap bit2 low: SPI/QSPI modes, no links
// - Strap bit2 high: channel boot, links on
// - PLL straps select ratio settings
// - Core clock from multiplier and dividers
// - Software may rewrite PLL settings
// - QSPI: clock/8, read address 0, low nibble first
// - SPI master: mode 0, address 0, LSB first
// - SPI slave: external clocking, LSB first
// - Link: ack word, image, end tokens
`ifndef BSIL_CONSTS_VH
`define BSIL_CONSTS_VH
`define BSIL_CLK_MHZ 20
`define BSIL_RST_SEQ_US 15
`define BSIL_RST_SEQ_CYC (`BSIL_RST_SEQ_US * `BSIL_CLK_MHZ)
`define BSIL_MAGIC 32'h0D15AB1E
`define BSIL_CRC_POLY 32'hEDB88320
`define BSIL_CRC_INIT 32'hFFFFFFFF
`define BSIL_NULL_CHAN 32'h0000FF02
`define BSIL_FLASH_ADDR 24'h000000
`define BSIL_EXEC_ADDR 32'h00000000
`define BSIL_SRC_QSPI 3'h0
`define BSIL_SRC_SPIM 3'h1
`define BSIL_SRC_SPIS 3'h2
`define BSIL_SRC_CHAN 3'h3
`define BSIL_SRC_OTP 3'h4
`define BSIL_LINKS_NONE 8'h00
`define BSIL_LINK_ZERO 8'h01
`define BSIL_LINKS_FOUR_TO_SEVEN 8'hF0
`define BSIL_LINKS_1256 8'h66
`define BSIL_LINKS_ZERO_TO_THREE 8'h0F
`define BSIL_F_R40 12'h09F
`define BSIL_F_R16 12'h03F
`define BSIL_F_R8 12'h01F
`define BSIL_F_R4 12'h00F
`define BSIL_OD_DEF 3'h1
`define BSIL_R_DEF 6'h00
`define BSIL_SCLK_HALF 2'h3
`endif

// [bsil_feeder.sv]
`timescale 1ns/1ns
module bsil_feeder (
	input wire clk_in,
	input wire stall_in,
	output reg valid_out = 1'b0,
	output reg [7:0] byte_out = 8'h00
);
	reg [7:0] q[$];
	// Idle line inverts the previous byte_out value on every idle cycle
	always @(posedge clk_in) begin
		if (q.size() > 0 && !stall_in) begin
			valid_out <= 1'b1;
			byte_out <= q.pop_front();
		end else begin
			valid_out <= 1'b0;
			byte_out <= ~byte_out;
		end
	end
endmodule // bsil_feeder

// [bsil_top.v]
`timescale 1ns/1ns
`include "bsil_consts.vh"
module bsil_top (
	input wire clk_in,
	input wire rst_in,
	input wire rst_pin_n_in,
	input wire boot_strap_bit0_in,
	input wire boot_strap_bit1_in,
	input wire boot_strap_bit2_in,
	input wire pll_strap_lo_in,
	input wire pll_strap_hi_in,
	input wire secure_boot_in,
	input wire pll_cfg_we_in,
	input wire [11:0] pll_mult_in,
	input wire [5:0] pll_in_div_in,
	input wire [2:0] pll_output_divider_in,
	input wire data_valid_in,
	input wire [7:0] data_in,
	input wire end_tok_in,
	output reg gpio_pd_out,
	output reg in_reset_out,
	output reg [2:0] tile0_src_out,
	output reg [2:0] tile1_src_out,
	output reg [7:0] link_en_out,
	output reg link_5w_out,
	output reg [11:0] pll_mult_out,
	output reg [5:0] pll_in_div_out,
	output reg [2:0] pll_output_divider_out,
	output reg [12:0] core_mult_out,
	output reg [10:0] core_div_out,
	output reg flash_rd_out,
	output reg [23:0] flash_addr_out,
	output reg sclk_out,
	output reg ram_we_out,
	output reg [31:0] ram_addr_out,
	output reg [31:0] ram_wdata_out,
	output reg start_out,
	output reg [31:0] exec_addr_out,
	output reg crc_skipped_out,
	output reg fail_out,
	output reg end_tok_send_out,
	output reg [31:0] ack_chan_out
);
	localparam ST_PINRST = 4'h0;
	localparam ST_SEQ = 4'h1;
	localparam ST_SAMPLE = 4'h2;
	localparam ST_ACK = 4'h3;
	localparam ST_LEN = 4'h4;
	localparam ST_PROG = 4'h5;
	localparam ST_CHK = 4'h6;
	localparam ST_ENDTOK = 4'h7;
	localparam ST_RUN = 4'h8;
	localparam ST_FAIL = 4'h9;
	localparam [15:0] SEQ_LAST = `BSIL_RST_SEQ_CYC - 1;

	function [31:0] crc_byte;
		input [31:0] c;
		input [7:0] b;
		integer i;
		reg [31:0] t;
		begin
			t = c ^ {24'h000000, b};
			for (i = 0; i < 8; i = i + 1) begin
				t = t[0] ? ((t >> 1) ^ `BSIL_CRC_POLY) : (t >> 1);
			end
			crc_byte = t;
		end
	endfunction

	reg [3:0] state_ff;
	reg [15:0] seq_cnt_ff;
	reg [7:0] bsh_ff;
	reg [3:0] bcnt_ff;
	reg [31:0] wsh_ff;
	reg [1:0] wcnt_ff;
	reg [31:0] len_ff;
	reg [31:0] crc_ff;
	reg [1:0] div_ff;
	reg link_boot_ff;
	reg first_wr_ff;
	reg [2:0] own_src_ff;
	reg [2:0] tsrc;
	reg [2:0] t1src;
	reg [7:0] lnk;
	reg l5w;
	reg [11:0] fmul;
	reg [7:0] nxt_bsh;
	reg [3:0] nxt_bcnt;
	reg [31:0] nxt_word;
	wire rx_state = (state_ff == ST_ACK) || (state_ff == ST_LEN) || (state_ff == ST_PROG) || (state_ff == ST_CHK);
	wire byte_done = rx_state && data_valid_in && (nxt_bcnt[3] == 1'b1);
	wire word_done = byte_done && (wcnt_ff == 2'h3);
	wire master_src = (own_src_ff == `BSIL_SRC_QSPI) || (own_src_ff == `BSIL_SRC_SPIM);
	wire [31:0] crc_fin = ~crc_ff;

	// Strap decode for both tiles, links and PLL
	always @* begin
		tsrc = `BSIL_SRC_CHAN;
		t1src = `BSIL_SRC_CHAN;
		lnk = `BSIL_LINKS_NONE;
		l5w = 1'b0;
		if (!boot_strap_bit2_in) begin
			if ({boot_strap_bit1_in, boot_strap_bit0_in} == 2'h0) begin
				tsrc = `BSIL_SRC_QSPI;
			end else if ({boot_strap_bit1_in, boot_strap_bit0_in} == 2'h1) begin
				tsrc = `BSIL_SRC_SPIM;
			end else if ({boot_strap_bit1_in, boot_strap_bit0_in} == 2'h2) begin
				tsrc = `BSIL_SRC_SPIS;
			end else begin
				tsrc = `BSIL_SRC_SPIS;
				t1src = `BSIL_SRC_SPIS;
			end
		end else begin
			l5w = 1'b1;
			if ({boot_strap_bit1_in, boot_strap_bit0_in} == 2'h0) begin
				lnk = `BSIL_LINK_ZERO;
				l5w = 1'b0;
			end else if ({boot_strap_bit1_in, boot_strap_bit0_in} == 2'h1) begin
				lnk = `BSIL_LINKS_FOUR_TO_SEVEN;
			end else if ({boot_strap_bit1_in, boot_strap_bit0_in} == 2'h2) begin
				lnk = `BSIL_LINKS_1256;
			end else begin
				lnk = `BSIL_LINKS_ZERO_TO_THREE;
			end
		end
		if (secure_boot_in) begin
			tsrc = `BSIL_SRC_OTP;
		end
		case ({pll_strap_hi_in, pll_strap_lo_in})
			2'h0: fmul = `BSIL_F_R40;
			2'h3: fmul = `BSIL_F_R16;
			2'h2: fmul = `BSIL_F_R8;
			default: fmul = `BSIL_F_R4;
		endcase
	end

	// Serial units arrive LSB or low nibble first
	always @* begin
		nxt_bsh = bsh_ff;
		nxt_bcnt = bcnt_ff;
		if (own_src_ff == `BSIL_SRC_QSPI) begin
			nxt_bsh = {data_in[3:0], bsh_ff[7:4]};
			nxt_bcnt = bcnt_ff + 4'h4;
		end else if ((own_src_ff == `BSIL_SRC_SPIM) || (own_src_ff == `BSIL_SRC_SPIS)) begin
			nxt_bsh = {data_in[0], bsh_ff[7:1]};
			nxt_bcnt = bcnt_ff + 4'h1;
		end else begin
			nxt_bsh = data_in;
			nxt_bcnt = 4'h8;
		end
		nxt_word = {nxt_bsh, wsh_ff[31:8]};
	end

	always @(posedge clk_in) begin
		if (rst_in || !rst_pin_n_in) begin
			state_ff <= ST_PINRST;
			gpio_pd_out <= 1'b1;
			in_reset_out <= 1'b1;
			seq_cnt_ff <= 16'h0000;
			bsh_ff <= 8'h00;
			bcnt_ff <= 4'h0;
			wsh_ff <= 32'h00000000;
			wcnt_ff <= 2'h0;
			len_ff <= 32'h00000000;
			crc_ff <= `BSIL_CRC_INIT;
			div_ff <= 2'h0;
			link_boot_ff <= 1'b0;
			first_wr_ff <= 1'b1;
			own_src_ff <= `BSIL_SRC_CHAN;
			tile0_src_out <= `BSIL_SRC_CHAN;
			tile1_src_out <= `BSIL_SRC_CHAN;
			link_en_out <= `BSIL_LINKS_NONE;
			link_5w_out <= 1'b0;
			pll_mult_out <= `BSIL_F_R4;
			pll_in_div_out <= `BSIL_R_DEF;
			pll_output_divider_out <= `BSIL_OD_DEF;
			core_mult_out <= 13'h0000;
			core_div_out <= 11'h000;
			flash_rd_out <= 1'b0;
			flash_addr_out <= `BSIL_FLASH_ADDR;
			sclk_out <= 1'b0;
			ram_we_out <= 1'b0;
			ram_addr_out <= `BSIL_EXEC_ADDR;
			ram_wdata_out <= 32'h00000000;
			start_out <= 1'b0;
			exec_addr_out <= `BSIL_EXEC_ADDR;
			crc_skipped_out <= 1'b0;
			fail_out <= 1'b0;
			end_tok_send_out <= 1'b0;
			ack_chan_out <= `BSIL_NULL_CHAN;
		end else begin
			gpio_pd_out <= 1'b0;
			flash_rd_out <= 1'b0;
			ram_we_out <= 1'b0;
			end_tok_send_out <= 1'b0;
			core_mult_out <= {1'b0, pll_mult_out} + 13'h0001;
			// Widened before the increment so R=63 and OD=7 do not wrap
			core_div_out <= {3'h0, {1'b0, pll_in_div_out} + 7'h01, 1'b0} * {7'h00, {1'b0, pll_output_divider_out} + 4'h1};
			if (pll_cfg_we_in && !in_reset_out) begin
				pll_mult_out <= pll_mult_in;
				pll_in_div_out <= pll_in_div_in;
				pll_output_divider_out <= pll_output_divider_in;
			end
			if (rx_state && master_src) begin
				div_ff <= div_ff + 2'h1;
				if (div_ff == `BSIL_SCLK_HALF) begin
					sclk_out <= ~sclk_out;
				end
			end else begin
				sclk_out <= 1'b0;
				div_ff <= 2'h0;
			end
			if (rx_state && data_valid_in) begin
				bsh_ff <= nxt_bsh;
				bcnt_ff <= byte_done ? 4'h0 : nxt_bcnt;
			end
			if (byte_done) begin
				wsh_ff <= nxt_word;
				wcnt_ff <= wcnt_ff + 2'h1;
				if ((state_ff == ST_LEN) || (state_ff == ST_PROG)) begin
					crc_ff <= crc_byte(crc_ff, nxt_bsh);
				end
			end
			case (state_ff)
				ST_PINRST: begin
					state_ff <= ST_SEQ;
					seq_cnt_ff <= 16'h0000;
				end
				ST_SEQ: begin
					seq_cnt_ff <= seq_cnt_ff + 16'h0001;
					if (seq_cnt_ff == SEQ_LAST) begin
						state_ff <= ST_SAMPLE;
					end
				end
				ST_SAMPLE: begin
					in_reset_out <= 1'b0;
					tile0_src_out <= tsrc;
					tile1_src_out <= t1src;
					own_src_ff <= tsrc;
					link_en_out <= lnk;
					link_5w_out <= l5w;
					pll_mult_out <= fmul;
					pll_in_div_out <= `BSIL_R_DEF;
					pll_output_divider_out <= `BSIL_OD_DEF;
					link_boot_ff <= (tsrc == `BSIL_SRC_CHAN);
					flash_rd_out <= (tsrc == `BSIL_SRC_QSPI) || (tsrc == `BSIL_SRC_SPIM);
					state_ff <= (tsrc == `BSIL_SRC_CHAN) ? ST_ACK : ST_LEN;
				end
				ST_ACK: begin
					if (word_done) begin
						ack_chan_out <= nxt_word;
						state_ff <= ST_LEN;
					end
				end
				ST_LEN: begin
					if (word_done) begin
						len_ff <= nxt_word;
						first_wr_ff <= 1'b1;
						state_ff <= (nxt_word == 32'h00000000) ? ST_CHK : ST_PROG;
					end
				end
				ST_PROG: begin
					if (word_done) begin
						ram_we_out <= 1'b1;
						ram_wdata_out <= nxt_word;
						ram_addr_out <= first_wr_ff ? `BSIL_EXEC_ADDR : ram_addr_out + 32'h00000004;
						first_wr_ff <= 1'b0;
						len_ff <= len_ff - 32'h00000001;
						if (len_ff == 32'h00000001) begin
							state_ff <= ST_CHK;
						end
					end
				end
				ST_CHK: begin
					if (word_done) begin
						if (nxt_word == `BSIL_MAGIC) begin
							crc_skipped_out <= 1'b1;
							state_ff <= link_boot_ff ? ST_ENDTOK : ST_RUN;
						end else if (nxt_word == crc_fin) begin
							state_ff <= link_boot_ff ? ST_ENDTOK : ST_RUN;
						end else begin
							fail_out <= 1'b1;
							state_ff <= ST_FAIL;
						end
					end
				end
				ST_ENDTOK: begin
					if (end_tok_in) begin
						end_tok_send_out <= (ack_chan_out != `BSIL_NULL_CHAN);
						state_ff <= ST_RUN;
					end
				end
				ST_RUN: begin
					start_out <= 1'b1;
					exec_addr_out <= `BSIL_EXEC_ADDR;
				end
				default: begin
					fail_out <= 1'b1;
				end
			endcase
		end
	end
endmodule // bsil_top

// [bsil_top_bench.sv]
`timescale 1ns/1ns
`include "bsil_consts.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module bsil_top_bench;
	reg clk_in = 0, rst_in = 0, rst_pin_n_in = 1, secure_boot_in = 0, pll_cfg_we_in = 0, end_tok_in = 0, stall = 0;
	reg boot_strap_bit0_in = 0, boot_strap_bit1_in = 0, boot_strap_bit2_in = 0, pll_strap_lo_in = 0, pll_strap_hi_in = 0;
	reg [11:0] pll_mult_in = 0, fv;
	reg [5:0] pll_in_div_in = 0, rv;
	reg [2:0] pll_output_divider_in = 0, ov, s;
	wire data_valid_in, gpio_pd_out, in_reset_out, link_5w_out, flash_rd_out, sclk_out, ram_we_out, start_out;
	wire crc_skipped_out, fail_out, end_tok_send_out;
	wire [7:0] data_in, link_en_out;
	wire [2:0] tile0_src_out, tile1_src_out, pll_output_divider_out;
	wire [11:0] pll_mult_out;
	wire [5:0] pll_in_div_out;
	wire [12:0] core_mult_out;
	wire [10:0] core_div_out;
	wire [23:0] flash_addr_out;
	wire [31:0] ram_addr_out, ram_wdata_out, exec_addr_out, ack_chan_out;
	integer err_total = 0, samples_checked = 0, cyc = 0, i, n, k, len;
	reg [15:0] rnd = 16'hDE7B;
	reg [31:0] crc, w;
	reg [31:0] exp_q[$];
	reg [29:0] wi = 0;
	bsil_top dut (.*);
	bsil_feeder src (.clk_in(clk_in), .stall_in(stall), .valid_out(data_valid_in), .byte_out(data_in));
	always #25 clk_in = ~clk_in;
	function [15:0] lfsr(input [15:0] x);
		lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function [31:0] crc_b(input [31:0] c, input [7:0] b);
		integer j;
		begin
			crc_b = c ^ {24'h0, b};
			for (j = 0; j < 8; j++) crc_b = crc_b[0] ? (crc_b >> 1) ^ `BSIL_CRC_POLY : crc_b >> 1;
		end
	endfunction
	function [7:0] links(input [2:0] x);
		case (x)
			3'h4: links = 8'h01;
			3'h5: links = 8'hF0;
			3'h6: links = 8'h66;
			3'h7: links = 8'h0F;
			default: links = 8'h00;
		endcase
	endfunction
	function [11:0] pllf(input [1:0] m);
		case (m)
			2'h0: pllf = 12'h09F;
			2'h1: pllf = 12'h00F;
			2'h2: pllf = 12'h01F;
			default: pllf = 12'h03F;
		endcase
	endfunction
	// Bytes go out least significant first
	task push_w(input [31:0] v, input c);
		integer j;
		for (j = 0; j < 4; j++) begin
			src.q.push_back(v[8*j+:8]);
			if (c) crc = crc_b(crc, v[8*j+:8]);
		end
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clk_in) begin
		rnd <= lfsr(rnd);
		stall <= rnd[0] & rnd[3];
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			finish_test;
		end
		if (in_reset_out) wi <= 0;
		else if (ram_we_out === 1'b1) begin
			`CHK("ram_addr", {wi, 2'b00}, ram_addr_out)
			`CHK("ram_wdata", exp_q.size() ? exp_q[0] : ~ram_wdata_out, ram_wdata_out)
			if (exp_q.size()) void'(exp_q.pop_front());
			wi <= wi + 30'h1;
		end
	end
	initial begin
		for (i = 0; i < 16; i++) begin
			@(posedge clk_in);
			s = i[2:0];
			{boot_strap_bit2_in, boot_strap_bit1_in, boot_strap_bit0_in} <= s;
			{pll_strap_hi_in, pll_strap_lo_in} <= i[1:0];
			secure_boot_in <= i[3];
			if (i[0]) rst_pin_n_in <= 0;
			else rst_in <= 1;
			pll_cfg_we_in <= 1;
			pll_mult_in <= rnd[11:0];
			repeat (2) @(posedge clk_in);
			rst_in <= 0;
			rst_pin_n_in <= 1;
			pll_cfg_we_in <= 0;
			#1 `CHK("gpio_pd", 1'b1, gpio_pd_out)
			n = 0;
			while (in_reset_out !== 1'b0 && n < 400) begin @(posedge clk_in); n++; end
			#1 `CHK("tile0", i[3] ? 3'h4 : s[2] ? 3'h3 : s[1] ? 3'h2 : {2'h0, s[0]}, tile0_src_out)
			`CHK("tile1", s == 3'h3 ? 3'h2 : 3'h3, tile1_src_out)
			`CHK("links", links(s), link_en_out)
			if (s[2]) `CHK("five_wire", s != 3'h4, link_5w_out)
			`CHK("pll_f", pllf(i[1:0]), pll_mult_out)
			`CHK("pll_r", 6'h00, pll_in_div_out)
			`CHK("pll_od", 3'h1, pll_output_divider_out)
			@(posedge clk_in);
			{boot_strap_bit2_in, boot_strap_bit1_in, boot_strap_bit0_in} <= ~s;
			if (i[3]) begin
				crc = `BSIL_CRC_INIT;
				len = i % 4;
				push_w(len, 1);
				for (k = 0; k < len; k++) begin
					@(posedge clk_in);
					w = {rnd, lfsr(rnd)};
					exp_q.push_back(w);
					push_w(w, 1);
				end
				w = (i % 3 == 1) ? `BSIL_MAGIC : ~crc ^ {31'h0, i % 3 == 2};
				push_w(w, 0);
				n = 0;
				while (start_out !== 1'b1 && fail_out !== 1'b1 && n < 300) begin @(posedge clk_in); n++; end
				@(posedge clk_in);
				#1 `CHK("start", i % 3 != 2, start_out)
				`CHK("fail", i % 3 == 2, fail_out)
				`CHK("skip", i % 3 == 1, crc_skipped_out)
				`CHK("words_left", 0, exp_q.size())
			end
			`CHK("tile1_held", s == 3'h3 ? 3'h2 : 3'h3, tile1_src_out)
			@(posedge clk_in);
			fv = rnd[11:0];
			rv = rnd[15:10];
			ov = rnd[6:4];
			pll_cfg_we_in <= 1;
			pll_mult_in <= fv;
			pll_in_div_in <= rv;
			pll_output_divider_in <= ov;
			@(posedge clk_in);
			pll_cfg_we_in <= 0;
			repeat (2) @(posedge clk_in);
			#1 `CHK("pll_f_new", fv, pll_mult_out)
			`CHK("core_mult", 13'(fv + 1), core_mult_out)
			`CHK("core_div", 11'(2 * (rv + 1) * (ov + 1)), core_div_out)
		end
		finish_test;
	end
endmodule // bsil_top_bench
